// ### cpss_bridge_model.sv
// timing node model: sawtooth compared against the control level
`timescale 1ns/1ps
`default_nettype none
module cpss_bridge_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic osc_reset,
  input wire logic [9:0] control_level,
  output logic sawtooth_at_control
);
  logic [10:0] ramp;
  logic [10:0] limit;
  assign limit = {1'b0, control_level};
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) ramp <= 11'h000;
    else if (osc_reset || ramp > limit + 11'h004) ramp <= 11'h000; // ramp discharged
    else ramp <= ramp + 11'h001;
  end
  assign sawtooth_at_control = (ramp >= limit); // higher level, longer half
endmodule : cpss_bridge_model
`default_nettype wire

// ### cpss_current_protect_standby.sv
// protection, overload hiccup and standby sequencer top
// Contract
// - current sense feeds a peak trip path and an averaged path.
// - peak above threshold either polarity ends on-time, resets oscillator.
// - peak trip judged fresh every half-cycle, never latched.
// - averaged current compared to frequency-adjusted overload threshold.
// - overload counter counts up above threshold, down below, per half-cycle.
// - net count reaching 16384 enters sleep and stops drive.
// - after shutdown wait 8 dummy restarts, about 2s, then start normally.
// - restart shuts down again if overload persists, else runs on.
// - constant-current limit holds average at 140mV preset level; here only current_limit_active is flagged in run, drive is not limited.
// - half-cycle ends when sawtooth reaches control level.
// - control level clamped between floor and ceiling.
// - supply-to-timing-node switch closed while sleeping.
// - standby entered at maximum frequency or at low load.
// - low load flagged when average below burst threshold; converter stops.
// - standby disconnects compensation and holds control level.
// - standby left when feedback sense drops by 100mV.
// - after exit stay out of standby until a half-cycle end sees maximum frequency or low load.
// - start pulses on both drive outputs first two cycles, 700ns each.
// - supply at start threshold moves sleep to run.
`timescale 1ns/1ps
`default_nettype none
module cpss_current_protect_standby
  import cpss_pkg::*;
#(
  parameter int DUMMY_CYC = DUMMY_PERIOD_CYC,
  parameter int OVL_TRIP = OVL_TRIP_COUNT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic peak_pos_above,
  input wire logic peak_neg_above,
  input wire logic avg_above_overload,
  input wire logic avg_above_limit,
  input wire logic avg_below_burst,
  input wire logic sawtooth_at_control,
  input wire logic freq_at_max,
  input wire logic feedback_exit_drop,
  input wire logic supply_at_start,
  input wire logic [9:0] control_in,
  output logic [9:0] control_level,
  output logic comp_connect,
  output logic current_limit_active,
  output logic osc_reset,
  output logic drive_output_a,
  output logic drive_output_b,
  output logic drive_enable,
  output logic supply_switch,
  output logic [1:0] mode,
  output logic overload_shutdown
);
  cpss_trip_if trip ();
  cpss_mode_t state;
  cpss_mode_t next_state;
  logic [OVL_CNT_W-1:0] ovl_cnt;
  logic [OVL_CNT_W-1:0] next_ovl_cnt;
  logic [31:0] dummy_cnt;
  logic [31:0] next_dummy_cnt;
  logic [3:0] dummy_num;
  logic [3:0] next_dummy_num;
  logic hiccup;
  logic next_hiccup;
  logic [1:0] start_cyc;
  logic [1:0] next_start_cyc;
  logic [7:0] pulse_cnt;
  logic [7:0] next_pulse_cnt;
  logic [9:0] held;
  logic [9:0] next_held;
  logic [9:0] clamped;
  logic trip_now;
  logic [9:0] next_control_level;
  logic next_comp_connect;
  logic next_current_limit_active;
  logic next_osc_reset;
  logic next_drive_output_a;
  logic next_drive_output_b;
  logic next_drive_enable;
  logic next_supply_switch;
  logic [1:0] next_mode;
  logic next_overload_shutdown;

  assign trip_now = peak_pos_above | peak_neg_above;
  assign trip.peak_trip = trip_now & (state == CPSS_RUN);
  assign trip.osc_end = sawtooth_at_control & (state == CPSS_RUN);

  cpss_half_timer cpss_half_timer_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .trip(trip)
  );

  always_comb begin
    clamped = control_in;
    if (control_in < CTRL_FLOOR) begin
      clamped = CTRL_FLOOR;
    end else if (control_in > CTRL_CEIL) begin
      clamped = CTRL_CEIL;
    end
  end

  always_comb begin
    next_state = state;
    next_ovl_cnt = ovl_cnt;
    next_dummy_cnt = dummy_cnt;
    next_dummy_num = dummy_num;
    next_hiccup = hiccup;
    next_start_cyc = start_cyc;
    next_pulse_cnt = (pulse_cnt != 8'h00) ? pulse_cnt - 8'h01 : 8'h00;
    next_held = held;
    unique case (state)
      CPSS_SLEEP: begin
        if (hiccup) begin
          if (dummy_cnt + 32'h1 >= 32'(DUMMY_CYC)) begin
            next_dummy_cnt = 32'h0;
            next_dummy_num = dummy_num + 4'h1;
            if (dummy_num + 4'h1 >= 4'(DUMMY_RESTARTS)) begin
              next_hiccup = 1'b0;
              next_dummy_num = 4'h0;
            end
          end else begin
            next_dummy_cnt = dummy_cnt + 32'h1;
          end
        end else if (supply_at_start) begin
          next_state = CPSS_RUN;
          next_ovl_cnt = '0;
          next_start_cyc = 2'(START_CYCLES);
          next_pulse_cnt = 8'(START_PULSE_CYC);
        end
      end
      CPSS_RUN: begin
        next_held = clamped;
        if (trip.half_end) begin
          if (start_cyc != 2'h0) begin
            next_start_cyc = start_cyc - 2'h1;
            if (start_cyc > 2'h1) begin
              next_pulse_cnt = 8'(START_PULSE_CYC);
            end
          end
          if (avg_above_overload) begin
            next_ovl_cnt = ovl_cnt + 15'h1;
          end else if (ovl_cnt != '0) begin
            next_ovl_cnt = ovl_cnt - 15'h1;
          end
          if (avg_above_overload && (ovl_cnt + 15'h1 >= 15'(OVL_TRIP))) begin
            next_state = CPSS_SLEEP;
            next_hiccup = 1'b1;
            next_dummy_cnt = 32'h0;
          end else if ((freq_at_max || avg_below_burst) && start_cyc == 2'h0) begin
            next_state = CPSS_STANDBY;
          end
        end
      end
      CPSS_STANDBY: begin
        if (feedback_exit_drop) begin
          next_state = CPSS_RUN;
        end
      end
      default: next_state = CPSS_SLEEP;
    endcase
  end

  always_comb begin
    next_control_level = (next_state == CPSS_RUN) ? clamped : next_held;
    next_comp_connect = (next_state == CPSS_RUN);
    next_current_limit_active = avg_above_limit & (state == CPSS_RUN);
    next_osc_reset = trip.half_end & (state == CPSS_RUN);
    next_drive_output_a = (next_pulse_cnt != 8'h00) & (next_state == CPSS_RUN);
    next_drive_output_b = (next_pulse_cnt != 8'h00) & (next_state == CPSS_RUN);
    next_drive_enable = (next_state == CPSS_RUN);
    next_supply_switch = (next_state == CPSS_SLEEP);
    next_mode = 2'(next_state);
    next_overload_shutdown = next_hiccup;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= CPSS_SLEEP;
      ovl_cnt <= '0;
      dummy_cnt <= 32'h0;
      dummy_num <= 4'h0;
      hiccup <= 1'b0;
      start_cyc <= 2'h0;
      pulse_cnt <= 8'h00;
      held <= CTRL_RESET;
    end else if (clk_en) begin
      state <= next_state;
      ovl_cnt <= next_ovl_cnt;
      dummy_cnt <= next_dummy_cnt;
      dummy_num <= next_dummy_num;
      hiccup <= next_hiccup;
      start_cyc <= next_start_cyc;
      pulse_cnt <= next_pulse_cnt;
      held <= next_held;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_level <= CTRL_RESET;
      comp_connect <= 1'b0;
      current_limit_active <= 1'b0;
      osc_reset <= 1'b0;
      drive_output_a <= 1'b0;
      drive_output_b <= 1'b0;
      drive_enable <= 1'b0;
      supply_switch <= 1'b1;
      mode <= 2'h0;
      overload_shutdown <= 1'b0;
    end else if (clk_en) begin
      control_level <= next_control_level;
      comp_connect <= next_comp_connect;
      current_limit_active <= next_current_limit_active;
      osc_reset <= next_osc_reset;
      drive_output_a <= next_drive_output_a;
      drive_output_b <= next_drive_output_b;
      drive_enable <= next_drive_enable;
      supply_switch <= next_supply_switch;
      mode <= next_mode;
      overload_shutdown <= next_overload_shutdown;
    end
  end

  chk_sleep_switch: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en |=> (supply_switch == (state == CPSS_SLEEP))) else $error("switch mismatch");
  chk_clamp_range: assert property (@(posedge clk) disable iff (sys_rst)
    control_level >= CTRL_FLOOR && control_level <= CTRL_CEIL) else $error("control out");
  chk_trip_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && trip.peak_trip && !$past(trip.peak_trip | trip.osc_end)) ##1 clk_en
    |=> osc_reset) else $error("no reset");
  chk_ovl_sleep: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && state == CPSS_RUN && trip.half_end && avg_above_overload
     && ovl_cnt == 15'(OVL_TRIP - 1)) |=> state == CPSS_SLEEP) else $error("no sleep");
  chk_ovl_floor: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && ovl_cnt == '0 && !avg_above_overload) |=> ovl_cnt == '0) else $error("wrap");
  chk_standby_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (state == CPSS_STANDBY && $past(state) == CPSS_STANDBY) |-> $stable(held))
    else $error("held moved");
  chk_standby_exit: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && state == CPSS_STANDBY && feedback_exit_drop) |=> state == CPSS_RUN)
    else $error("no exit");
  chk_pulse_len: assert property (@(posedge clk) disable iff (sys_rst)
    pulse_cnt <= 8'(START_PULSE_CYC)) else $error("pulse long");

  chk_drive_pair: assert property (@(posedge clk) disable iff (sys_rst)
    drive_output_a == drive_output_b)
    else $error("drive outputs differ");

  chk_drive_run: assert property (@(posedge clk) disable iff (sys_rst)
    drive_output_a |-> drive_enable)
    else $error("start pulse outside run");

  chk_comp_run: assert property (@(posedge clk) disable iff (sys_rst)
    comp_connect == (mode == 2'h1))
    else $error("compensation link wrong");

  chk_drive_state: assert property (@(posedge clk) disable iff (sys_rst)
    drive_enable == (state == CPSS_RUN))
    else $error("drive enable wrong");

  chk_trip_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && state != CPSS_RUN) |=> !trip.half_end)
    else $error("half end outside run");

  chk_ovl_up: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && state == CPSS_RUN && trip.half_end && avg_above_overload
     && ovl_cnt < 15'(OVL_TRIP - 1)) |=> ovl_cnt == $past(ovl_cnt) + 15'h1)
    else $error("overload count not up");

  chk_ovl_down: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && state == CPSS_RUN && trip.half_end && !avg_above_overload
     && ovl_cnt != '0) |=> ovl_cnt == $past(ovl_cnt) - 15'h1)
    else $error("overload count not down");

  chk_ovl_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && state == CPSS_RUN && !trip.half_end) |=> $stable(ovl_cnt))
    else $error("overload count moved mid cycle");

  chk_restart_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (state == CPSS_SLEEP ##1 state == CPSS_RUN) |-> ovl_cnt == '0)
    else $error("overload count kept on restart");

  chk_hiccup_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && hiccup && state == CPSS_SLEEP) |=> state == CPSS_SLEEP)
    else $error("early restart");

  chk_wake_run: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && state == CPSS_SLEEP && !hiccup && supply_at_start) |=> state == CPSS_RUN)
    else $error("no wake");

  chk_standby_start: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && state == CPSS_RUN && start_cyc != 2'h0) |=> state != CPSS_STANDBY)
    else $error("standby during start");

  chk_standby_enter: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && state == CPSS_RUN && trip.half_end && start_cyc == 2'h0
     && avg_below_burst && !avg_above_overload) |=> state == CPSS_STANDBY)
    else $error("no standby entry");

  chk_standby_level: assert property (@(posedge clk) disable iff (sys_rst)
    (state == CPSS_STANDBY) |-> control_level == held)
    else $error("standby level not held");

  chk_run_stay: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && state == CPSS_RUN && !trip.half_end) |=> state == CPSS_RUN)
    else $error("left run mid cycle");

  chk_limit_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && state == CPSS_RUN && avg_above_limit) |=> current_limit_active)
    else $error("limit flag missing");
endmodule : cpss_current_protect_standby
`default_nettype wire

// ### cpss_current_protect_standby_tb_top.sv
// testbench for the protection and standby sequencer
`timescale 1ns/1ps
`default_nettype none
module cpss_current_protect_standby_tb_top;
  import cpss_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic peak_pos_above = 1'b0, peak_neg_above = 1'b0, avg_above_overload = 1'b0;
  logic avg_above_limit = 1'b0, avg_below_burst = 1'b0, freq_at_max = 1'b0;
  logic feedback_exit_drop = 1'b0, supply_at_start = 1'b0, sawtooth_at_control;
  logic [9:0] control_in = 10'h1ef;
  logic [9:0] control_level, held;
  logic comp_connect, current_limit_active, osc_reset, drive_output_a, drive_output_b;
  logic drive_enable, supply_switch, overload_shutdown;
  logic [1:0] mode;
  int fails = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  cpss_current_protect_standby #(.DUMMY_CYC(10), .OVL_TRIP(4)) cpss_current_protect_standby_inst (
    .clk, .sys_rst, .clk_en, .peak_pos_above, .peak_neg_above, .avg_above_overload,
    .avg_above_limit, .avg_below_burst, .sawtooth_at_control, .freq_at_max,
    .feedback_exit_drop, .supply_at_start, .control_in, .control_level, .comp_connect,
    .current_limit_active, .osc_reset, .drive_output_a, .drive_output_b, .drive_enable,
    .supply_switch, .mode, .overload_shutdown);
  cpss_bridge_model cpss_bridge_model_inst (.clk, .sys_rst, .osc_reset, .control_level,
    .sawtooth_at_control);
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wait_mode(input logic [1:0] m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) step(1);
    chk("mode", 10'(m), 10'(mode));
  endtask : wait_mode
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic t_start;
    supply_at_start = 1'b1;
    step(1);
    supply_at_start = 1'b0;
    chk("mode", 10'h001, 10'(mode));
    chk("supply_switch", 10'h000, 10'(supply_switch));
    chk("drive_a", 10'h001, 10'(drive_output_a));
    chk("drive_b", 10'h001, 10'(drive_output_b));
    step(139);
    chk("drive_a", 10'h001, 10'(drive_output_a));
    step(1);
    chk("drive_a", 10'h000, 10'(drive_output_a));
    chk("drive_b", 10'h000, 10'(drive_output_b));
  endtask : t_start
  task automatic t_peak;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 1000 && osc_reset !== 1'b1; i++) step(1);
      step(2);
      peak_pos_above = (p == 0);
      peak_neg_above = (p == 1);
      step(1);
      peak_pos_above = 1'b0;
      peak_neg_above = 1'b0;
      chk("osc_reset early", 10'h000, 10'(osc_reset));
      step(1);
      chk("osc_reset trip", 10'h001, 10'(osc_reset));
      step(1);
      chk("osc_reset end", 10'h000, 10'(osc_reset));
    end
  endtask : t_peak
  task automatic t_clamp;
    logic [9:0] ins [3] = '{10'h000, 10'h3ff, 10'h200};
    logic [9:0] outs [3] = '{CTRL_FLOOR, CTRL_CEIL, 10'h200};
    for (int i = 0; i < 3; i++) begin
      control_in = ins[i];
      step(4);
      chk("control_level", outs[i], control_level);
    end
    clk_en = 1'b0;
    control_in = 10'h000;
    step(4);
    chk("control_level", 10'h200, control_level);
    clk_en = 1'b1;
    control_in = 10'h1ef;
    avg_above_limit = 1'b1;
    step(3);
    chk("limit", 10'h001, 10'(current_limit_active));
    avg_above_limit = 1'b0;
    step(3);
    chk("limit", 10'h000, 10'(current_limit_active));
  endtask : t_clamp
  task automatic t_standby;
    avg_below_burst = 1'b1;
    wait_mode(2'h2, 1200);
    chk("comp_connect", 10'h000, 10'(comp_connect));
    held = control_level;
    control_in = 10'h300;
    step(5);
    chk("control_level", held, control_level);
    avg_below_burst = 1'b0;
    feedback_exit_drop = 1'b1;
    wait_mode(2'h1, 400);
    feedback_exit_drop = 1'b0;
    chk("comp_connect", 10'h001, 10'(comp_connect));
    step(200);
    chk("mode", 10'h001, 10'(mode));
    control_in = 10'h1ef;
    freq_at_max = 1'b1;
    wait_mode(2'h2, 1200);
    freq_at_max = 1'b0;
    feedback_exit_drop = 1'b1;
    wait_mode(2'h1, 400);
    feedback_exit_drop = 1'b0;
  endtask : t_standby
  task automatic t_overload;
    supply_at_start = 1'b1;
    control_in = 10'h000;
    avg_above_overload = 1'b1;
    wait_mode(2'h0, 1200);
    chk("overload", 10'h001, 10'(overload_shutdown));
    chk("drive_enable", 10'h000, 10'(drive_enable));
    chk("supply_switch", 10'h001, 10'(supply_switch));
    step(70);
    chk("mode", 10'h000, 10'(mode));
    wait_mode(2'h1, 400);
    wait_mode(2'h0, 1200);
    avg_above_overload = 1'b0;
    wait_mode(2'h1, 400);
    supply_at_start = 1'b0;
    step(600);
    chk("mode", 10'h001, 10'(mode));
  endtask : t_overload
  initial begin
    step(5);
    chk("mode", 10'h000, 10'(mode));
    chk("supply_switch", 10'h001, 10'(supply_switch));
    chk("control_level", CTRL_RESET, control_level);
    step(1);
    sys_rst = 1'b0;
    step(1);
    t_start();
    t_peak();
    t_clamp();
    t_standby();
    t_overload();
    wrap_up();
  end
  initial begin
    #100us;
    fails++;
    wrap_up();
  end
endmodule : cpss_current_protect_standby_tb_top
`default_nettype wire

// ### cpss_half_timer.sv
// half-cycle end decision from oscillator and peak trip comparators
`timescale 1ns/1ps
`default_nettype none
module cpss_half_timer
  import cpss_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  cpss_trip_if.timer trip
);
  logic half_end;
  logic next_half_end;
  logic level_seen;
  logic next_level_seen;
  always_comb begin
    next_level_seen = trip.osc_end | trip.peak_trip;
    next_half_end = next_level_seen & ~level_seen; // one event per half-cycle
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_end <= 1'b0;
      level_seen <= 1'b0;
    end else if (clk_en) begin
      half_end <= next_half_end;
      level_seen <= next_level_seen;
    end
  end
  assign trip.half_end = half_end;
endmodule : cpss_half_timer
`default_nettype wire

// ### cpss_pkg.sv
// constants and types for the current protection and standby sequencer
package cpss_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int START_PULSE_NS = 700;
  localparam int START_PULSE_CYC = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_CYCLES = 2;
  localparam int OVL_TRIP_COUNT = 16384;
  localparam int OVL_CNT_W = 15;
  localparam int DUMMY_RESTARTS = 8;
  localparam int RESTART_TOTAL_MS = 2000;
  localparam int DUMMY_PERIOD_MS = RESTART_TOTAL_MS / DUMMY_RESTARTS;
  localparam int DUMMY_PERIOD_CYC = DUMMY_PERIOD_MS * 200000;
  localparam int CTRL_W = 10;
  localparam logic [9:0] CTRL_FLOOR = 10'h0bc;
  localparam logic [9:0] CTRL_CEIL = 10'h323;
  localparam logic [9:0] CTRL_RESET = 10'h1ef;
  typedef enum logic [1:0] {CPSS_SLEEP, CPSS_RUN, CPSS_STANDBY} cpss_mode_t;
endpackage : cpss_pkg

// ### cpss_trip_if.sv
// peak trip path between top and the half-cycle timer
`timescale 1ns/1ps
`default_nettype none
interface cpss_trip_if;
  logic osc_end;
  logic peak_trip;
  logic half_end;
  modport timer (input osc_end, input peak_trip, output half_end);
  modport top (output osc_end, output peak_trip, input half_end);
endinterface : cpss_trip_if
`default_nettype wire
